// >>> pnd_board_model.sv
// Board side of the port 0 pins
`timescale 1ns/10ps
`default_nettype none
module pnd_board_model import pnd_pkg::*; (
	input  wire logic [7:0] drive_in,
	input  wire logic [7:0] pin_out_in,
	input  wire logic [7:0] oe_n_in,
	input  wire logic       pulldown_in,
	input  wire logic       tool_drive_in,
	output var  logic [7:0] pin_level_out
);
	// Debug tool drives bit 5 strongly, over the weak pull-down
	assign pin_level_out = ~oe_n_in & pin_out_in
		| oe_n_in & drive_in & ~{2'h0, pulldown_in, 5'h00}
		| {2'h0, tool_drive_in & drive_in[DBG_BIT], 5'h00};
endmodule : pnd_board_model
`default_nettype wire

// >>> pnd_pin_select.sv
// Port 0 pin function select with nmi and debug reset sharing
`timescale 1ns/10ps
`default_nettype none
module pnd_pin_select
	import pnd_pkg::*;
(
	input  wire logic         SYS_CLK_IN,
	input  wire logic         SYS_RST_IN,
	input  wire logic [3:0]   ADDR_IN,
	input  wire logic [7:0]   WDATA_IN,
	input  wire logic         WR_IN,
	input  wire logic         RD_IN,
	output var  logic [7:0]   RDATA_OUT,
	input  wire logic [7:0]   PIN_IN,
	output var  logic [7:0]   PIN_OUT,
	output var  logic [7:0]   PIN_OE_N_OUT,
	output var  logic         PULLDOWN_EN_OUT,
	output var  logic         NMI_OUT,
	output var  logic         DEBUG_RESET_OUT
);
	pnd_bus_s   bus;
	logic [7:0] sync1_r;
	logic [7:0] sync2_r;
	logic [7:0] port_r;
	logic [7:0] port_nxt;
	logic [7:0] dir_r;
	logic [7:0] mode_r;
	logic [7:0] rise_r;
	logic [7:0] fall_r;
	logic       dbg_en_r;
	logic       nmi_prev_r;
	logic       nmi_seen_r;
	logic [7:0] pin_view;
	logic       nmi_edge;

	assign bus = '{addr: ADDR_IN, wdata: WDATA_IN, wr: WR_IN, rd: RD_IN};

	function automatic logic [7:0] bit_mask(input logic [2:0] idx);
		bit_mask = 8'h01 << idx;
	endfunction : bit_mask

	// Write strobe aimed at one register address
	function automatic logic wr_hit(input pnd_bus_s b, input logic [3:0] a);
		wr_hit = b.wr && (b.addr == a);
	endfunction : wr_hit

	always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN)
	begin
		if (SYS_RST_IN)
		begin
			sync1_r <= 8'h00;
			sync2_r <= 8'h00;
		end
		else
		begin
			sync1_r <= PIN_IN;
			sync2_r <= sync1_r;
		end
	end

	// Read view: output pins return latch, input pins return pin level
	assign pin_view = (dir_r & sync2_r) | (~dir_r & port_r);

	// Byte-wide read-modify-write; input latches take pin level
	always_comb
	begin
		port_nxt = port_r;
		if (bus.wr && bus.addr == ADDR_PORT)
		begin
			port_nxt = bus.wdata;
		end
		else if (bus.wr && bus.addr == ADDR_BITSET)
		begin
			port_nxt = pin_view | bit_mask(bus.wdata[2:0]);
		end
		else if (bus.wr && bus.addr == ADDR_BITCLR)
		begin
			port_nxt = pin_view & ~bit_mask(bus.wdata[2:0]);
		end
	end

	always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN)
	begin
		if (SYS_RST_IN)
			port_r <= PORT_RST;
		else
			port_r <= port_nxt;
	end

	always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN)
	begin
		if (SYS_RST_IN)
			dir_r <= DIR_RST;
		else if (wr_hit(bus, ADDR_DIR))
			dir_r <= bus.wdata;
	end

	always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN)
	begin
		if (SYS_RST_IN)
			mode_r <= MODE_RST;
		else if (wr_hit(bus, ADDR_MODE))
			mode_r <= bus.wdata;
	end

	always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN)
	begin
		if (SYS_RST_IN)
			rise_r <= EDGE_RST;
		else if (wr_hit(bus, ADDR_RISE))
			rise_r <= bus.wdata;
	end

	always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN)
	begin
		if (SYS_RST_IN)
			fall_r <= EDGE_RST;
		else if (wr_hit(bus, ADDR_FALL))
			fall_r <= bus.wdata;
	end

	// Debug function selected on reset; only software clears it
	always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN)
	begin
		if (SYS_RST_IN)
			dbg_en_r <= DBG_RST;
		else if (bus.wr && bus.addr == ADDR_DBG)
			dbg_en_r <= bus.wdata[0];
	end

	// Nmi edge detection on the synchronised bit 2 pin
	assign nmi_edge = mode_r[NMI_BIT]
		&& ((rise_r[NMI_BIT] && sync2_r[NMI_BIT] && !nmi_prev_r)
		|| (fall_r[NMI_BIT] && !sync2_r[NMI_BIT] && nmi_prev_r));

	always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN)
	begin
		if (SYS_RST_IN)
			nmi_prev_r <= 1'b0;
		else
			nmi_prev_r <= sync2_r[NMI_BIT];
	end

	always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN)
	begin
		if (SYS_RST_IN)
			NMI_OUT <= 1'b0;
		else
			NMI_OUT <= nmi_edge;
	end

	// Sticky edge flag; a new edge wins over a clear
	always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN)
	begin
		if (SYS_RST_IN)
			nmi_seen_r <= 1'b0;
		else if (nmi_edge)
			nmi_seen_r <= 1'b1;
		else if (wr_hit(bus, ADDR_NMIST) && bus.wdata[0])
			nmi_seen_r <= 1'b0;
	end

	always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN)
	begin
		if (SYS_RST_IN)
			PULLDOWN_EN_OUT <= 1'b1;
		else
			PULLDOWN_EN_OUT <= dbg_en_r;
	end

	always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN)
	begin
		if (SYS_RST_IN)
			DEBUG_RESET_OUT <= 1'b0;
		else
			DEBUG_RESET_OUT <= dbg_en_r & sync2_r[DBG_BIT];
	end

	// Pins drive only as port outputs; bit 5 never drives in debug use
	always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN)
	begin
		if (SYS_RST_IN)
			PIN_OUT <= PORT_RST;
		else
			PIN_OUT <= port_nxt;
	end

	always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN)
	begin
		if (SYS_RST_IN)
			PIN_OE_N_OUT <= 8'hFF;
		else
			PIN_OE_N_OUT <= dir_r | (mode_r & bit_mask(3'(NMI_BIT)))
				| ({7'h00, dbg_en_r} << DBG_BIT);
	end

	always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN)
	begin
		if (SYS_RST_IN)
			RDATA_OUT <= 8'h00;
		else if (bus.rd)
		begin
			if (bus.addr == ADDR_PORT)
				RDATA_OUT <= pin_view;
			else if (bus.addr == ADDR_DIR)
				RDATA_OUT <= dir_r;
			else if (bus.addr == ADDR_MODE)
				RDATA_OUT <= mode_r;
			else if (bus.addr == ADDR_RISE)
				RDATA_OUT <= rise_r;
			else if (bus.addr == ADDR_FALL)
				RDATA_OUT <= fall_r;
			else if (bus.addr == ADDR_DBG)
				RDATA_OUT <= {7'h00, dbg_en_r};
			else if (bus.addr == ADDR_NMIST)
				RDATA_OUT <= {7'h00, nmi_seen_r};
			else
				RDATA_OUT <= 8'h00;
		end
		else
			RDATA_OUT <= 8'h00;
	end
endmodule : pnd_pin_select
`default_nettype wire

// >>> pnd_pin_select_assertions.sv
// Port checker for the pin select
`timescale 1ns/10ps
`default_nettype none
module pnd_pin_select_assertions import pnd_pkg::*; (
	input wire logic       SYS_CLK_IN,
	input wire logic       SYS_RST_IN,
	input wire logic [3:0] ADDR_IN,
	input wire logic [7:0] WDATA_IN,
	input wire logic       WR_IN,
	input wire logic [7:0] PIN_IN,
	input wire logic [7:0] PIN_OUT,
	input wire logic [7:0] PIN_OE_N_OUT,
	input wire logic       PULLDOWN_EN_OUT,
	input wire logic       NMI_OUT,
	input wire logic       DEBUG_RESET_OUT
);
	default clocking @(posedge SYS_CLK_IN); endclocking
	default disable iff (SYS_RST_IN);
	AST_PORT_RST: assert property ($fell(SYS_RST_IN) |-> &PIN_OE_N_OUT) else $error("oe");
	AST_NMI_QUIET: assert property ($fell(SYS_RST_IN) |-> !NMI_OUT [*3]) else $error("nmi");
	AST_DBG_RST: assert property ($fell(SYS_RST_IN) |-> PULLDOWN_EN_OUT) else $error("dbg");
	AST_DBG_LOW: assert property (!PIN_IN[DBG_BIT] [*3]
		|=> !DEBUG_RESET_OUT) else $error("debug_reset_in");
	AST_PD_OFF: assert property (WR_IN && ADDR_IN == ADDR_DBG && !WDATA_IN[0]
		|=> ##1 !PULLDOWN_EN_OUT) else $error("pull");
	AST_BIT_SET: assert property (WR_IN && ADDR_IN == ADDR_BITSET
		|=> PIN_OUT[$past(WDATA_IN[2:0])]) else $error("set");
endmodule : pnd_pin_select_assertions
`default_nettype wire

// >>> pnd_pin_select_tb.sv
// Pin select testbench
`timescale 1ns/10ps
`default_nettype none
module pnd_pin_select_tb;
	import pnd_pkg::*;
	logic       SYS_CLK_IN = 0, SYS_RST_IN = 1, WR_IN = 0, RD_IN = 0, PULLDOWN_EN_OUT, NMI_OUT;
	logic       DEBUG_RESET_OUT, tool = 0;
	logic [3:0] ADDR_IN = 0;
	logic [7:0] WDATA_IN = 0, RDATA_OUT, PIN_IN, PIN_OUT, PIN_OE_N_OUT, dv = 0;
	int         n_fail = 0, n_checks = 0, ns = 0, seed = 32'h1E13;
	pnd_pin_select u_dut (.*);
	pnd_board_model u_brd (.drive_in(dv), .pin_out_in(PIN_OUT), .oe_n_in(PIN_OE_N_OUT),
		.pulldown_in(PULLDOWN_EN_OUT), .tool_drive_in(tool), .pin_level_out(PIN_IN));
	initial forever #2 SYS_CLK_IN = ~SYS_CLK_IN;
	always @(posedge SYS_CLK_IN) ns <= ns + NMI_OUT;
	task automatic ck(input string s, input logic [7:0] x, input logic [7:0] y);
		n_checks++;
		n_fail += int'(x !== y);
		if (x !== y)
			$display("[FAIL] %s exp %h got %h", s, x, y);
	endtask : ck
	task automatic op(input logic w, input logic [3:0] a, input logic [7:0] d);
		@(posedge SYS_CLK_IN);
		{WR_IN, RD_IN, ADDR_IN, WDATA_IN} <= {w, !w, a, d};
		@(posedge SYS_CLK_IN);
		{WR_IN, RD_IN} <= 2'h0;
		#1;
		if (!w)
			ck("rdata", d, RDATA_OUT);
	endtask : op
	task automatic pulse(input logic [7:0] n);
		repeat (2)
		begin
			dv[NMI_BIT] <= !dv[NMI_BIT];
			repeat (6) @(posedge SYS_CLK_IN);
		end
		ck("nmi", n, ns[7:0]);
	endtask : pulse
	task automatic print_verdict;
		$display("checks %0d fails %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : print_verdict
	initial
	begin
		repeat (12) @(posedge SYS_CLK_IN);
		SYS_RST_IN <= 1'b0;
		op(1'b0, ADDR_DBG, 8'h01);
		ck("pd", 8'h01, {7'h00, PULLDOWN_EN_OUT});
		ck("oe", 8'hFF, PIN_OE_N_OUT);
		{tool, dv[DBG_BIT]} <= 2'b11;
		repeat (4) @(posedge SYS_CLK_IN);
		#1 ck("debug_reset_in", 8'h01, {7'h00, DEBUG_RESET_OUT});
		{tool, dv[DBG_BIT]} <= 2'b00;
		repeat (4) @(posedge SYS_CLK_IN);
		#1 ck("debug_reset_in", 8'h00, {7'h00, DEBUG_RESET_OUT});
		op(1'b0, 4'hF, 8'h00);
		pulse(8'h00);
		op(1'b1, ADDR_MODE, 8'h04);
		pulse(8'h00);
		op(1'b1, ADDR_RISE, 8'h04);
		pulse(8'h01);
		op(1'b1, ADDR_FALL, 8'h04);
		pulse(8'h03);
		op(1'b0, ADDR_NMIST, 8'h01);
		op(1'b1, ADDR_NMIST, 8'h01);
		op(1'b0, ADDR_NMIST, 8'h00);
		op(1'b1, ADDR_DBG, 8'h00);
		repeat (2) @(posedge SYS_CLK_IN);
		#1 ck("pd", 8'h00, {7'h00, PULLDOWN_EN_OUT});
		$display("nmi and debug test done");
		op(1'b1, ADDR_DIR, 8'h0F);
		for (int i = 4; i < 8; i++)
		begin
			dv <= 8'($random(seed));
			op(1'b1, ADDR_PORT, 8'h00);
			ck("oe", 8'h0F, PIN_OE_N_OUT);
			op(1'b1, ADDR_BITSET, 8'(i));
			ck("latch", {4'h0, dv[3:0]} | 8'h01 << i, PIN_OUT);
			op(1'b0, ADDR_PORT, {4'h0, dv[3:0]} | 8'h01 << i);
		end
		$display("bit write test done");
		print_verdict();
	end
endmodule : pnd_pin_select_tb
bind pnd_pin_select pnd_pin_select_assertions u_chk (.*);
`default_nettype wire

// >>> pnd_pkg.sv
// Package for port 0 pin select with nmi and debug reset sharing
package pnd_pkg;
	localparam int PORT_W = 8;
	localparam int NMI_BIT = 2;
	localparam int DBG_BIT = 5;
	localparam logic [3:0] ADDR_PORT = 4'h0;
	localparam logic [3:0] ADDR_DIR = 4'h1;
	localparam logic [3:0] ADDR_MODE = 4'h2;
	localparam logic [3:0] ADDR_RISE = 4'h3;
	localparam logic [3:0] ADDR_FALL = 4'h4;
	localparam logic [3:0] ADDR_DBG = 4'h5;
	localparam logic [3:0] ADDR_BITSET = 4'h6;
	localparam logic [3:0] ADDR_BITCLR = 4'h7;
	localparam logic [3:0] ADDR_NMIST = 4'h8;
	localparam logic [7:0] PORT_RST = 8'h00;
	localparam logic [7:0] DIR_RST = 8'hFF;
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] EDGE_RST = 8'h00;
	localparam logic DBG_RST = 1'b1;
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} pnd_bus_s;
endpackage : pnd_pkg
